// *** rtl/bio_consts.vh ***
// Purpose: Shared constants for the binary input / output relay block
// Assumes: 40 MHz system clock, 1 ms time base
// Notes: Offsets are byte addresses on the AXI4-Lite register bus
`ifndef BIO_CONSTS_VH
`define BIO_CONSTS_VH

// Sizes
`define BIO_NUM_IN 8
`define BIO_NUM_REL 6
`define BIO_NUM_SLOT 7
`define BIO_SEL_W 4

// Time base
`define BIO_CLK_HZ 40000000
`define BIO_MS_PER_S 1000
`define BIO_TICK_MS 1

// Debounce choices in ms and their select codes
`define BIO_DEB_20_MS 20
`define BIO_DEB_50_MS 50
`define BIO_DEB_100_MS 100
`define BIO_DSEL_NONE 2'h0
`define BIO_DSEL_20 2'h1
`define BIO_DSEL_50 2'h2
`define BIO_DSEL_100 2'h3

// Register byte offsets
`define BIO_OFF_INCFG 8'h00
`define BIO_OFF_ACK 8'h04
`define BIO_OFF_STAT 8'h08
`define BIO_OFF_REL_BASE 8'h10
`define BIO_REL_SHIFT 3

// Input config fields
`define BIO_INCFG_INV_LSB 0
`define BIO_INCFG_DEB_LSB 16

// Acknowledge register fields
`define BIO_ACK_SCADA 0
`define BIO_ACK_EXT_SEL_LSB 4
`define BIO_ACK_EXT_EN 8
`define BIO_ACK_MASK 32'h0000_01F0

// Relay control fields
`define BIO_CTL_EN_LSB 0
`define BIO_CTL_INV_LSB 7
`define BIO_CTL_OUTINV 14
`define BIO_CTL_LATCH 15
`define BIO_CTL_ACKEN 16
`define BIO_CTL_ACKSEL_LSB 17
`define BIO_CTL_HOLD_LSB 24
`define BIO_CTL_MASK 32'hFF1F_FFFF
`define BIO_SEL_MASK 32'h0FFF_FFFF

// Status fields
`define BIO_STAT_REL_LSB 8
`define BIO_STAT_LAT_LSB 16

// Bus responses
`define BIO_RESP_OKAY 2'h0
`define BIO_RESP_SLVERR 2'h2

`endif

// *** rtl/bio_input_filter.v ***
// Purpose: One binary input: synchroniser, polarity and debounce
// Assumes: tick_i is a one-cycle pulse every millisecond
// Notes: A delay of N ms needs N+1 ticks, so the level has held N ms
`include "bio_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module bio_input_filter (
  input wire mclk_i,
  input wire resetn_i,
  input wire tick_i,
  input wire raw_i,
  input wire invert_i,
  input wire [1:0] delay_sel_i,
  output wire level_o
);

  localparam integer LIM_20_I = `BIO_DEB_20_MS / `BIO_TICK_MS + 1;
  localparam integer LIM_50_I = `BIO_DEB_50_MS / `BIO_TICK_MS + 1;
  localparam integer LIM_100_I = `BIO_DEB_100_MS / `BIO_TICK_MS + 1;
  localparam [6:0] LIM_20 = LIM_20_I[6:0];
  localparam [6:0] LIM_50 = LIM_50_I[6:0];
  localparam [6:0] LIM_100 = LIM_100_I[6:0];

  reg sync1_reg;
  reg sync2_reg;
  reg cand_reg;
  reg level_reg;
  reg [6:0] cnt_reg;
  wire [6:0] lim;

  assign lim = (delay_sel_i == `BIO_DSEL_20) ? LIM_20 :
               (delay_sel_i == `BIO_DSEL_50) ? LIM_50 : LIM_100;
  assign level_o = level_reg;

  // Two stages first, then only the second stage is looked at
  always @(posedge mclk_i)
  begin
    if (!resetn_i)
    begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      cand_reg <= 1'b0;
      cnt_reg <= 7'h00;
      level_reg <= 1'b0;
    end
    else
    begin
      sync1_reg <= raw_i;
      sync2_reg <= sync1_reg;
      cand_reg <= sync2_reg;
      // Any change of the raw level restarts the count
      if (sync2_reg != cand_reg)
        cnt_reg <= 7'h00;
      else if (tick_i && (cnt_reg != lim))
        cnt_reg <= cnt_reg + 7'h01;
      if (delay_sel_i == `BIO_DSEL_NONE)
        level_reg <= sync2_reg ^ invert_i;
      else if ((sync2_reg == cand_reg) && (cnt_reg == lim))
        level_reg <= cand_reg ^ invert_i;
    end
  end

endmodule // bio_input_filter

`default_nettype wire

// *** rtl/bio_debounce_latch.v ***
// Purpose: Binary input conditioning and output relay logic with latching
// Assumes: AXI4-Lite register access, 40 MHz clock, nonvolatile store outside
// Notes: Signal list index 0..7 are filtered inputs, 8..15 int_sig_i
//
// The register addresses and the AXI4-Lite interface to the registers are this design's own decisions.
`include "bio_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module bio_debounce_latch #(
  parameter TICK_CYCLES = `BIO_CLK_HZ / `BIO_MS_PER_S * `BIO_TICK_MS
) (
  input wire mclk_i,
  input wire resetn_i,
  input wire [7:0] sense_input_n_i,
  input wire [7:0] int_sig_i,
  input wire clear_key_i,
  input wire [5:0] nv_latch_i,
  input wire nv_valid_i,
  output wire [5:0] relay_o,
  output wire [5:0] nv_latch_o,
  output wire [7:0] input_state_o,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready
);

  localparam integer TICK_LAST_I = TICK_CYCLES - 1;
  localparam [15:0] TICK_LAST = TICK_LAST_I[15:0];

  // Time base
  reg [15:0] tick_cnt_reg;
  reg tick_reg;
  // Configuration
  reg [31:0] incfg_reg;
  reg [31:0] ack_reg;
  reg [27:0] sel_reg [0:5];
  reg [31:0] ctl_reg [0:5];
  reg scada_pulse_reg;
  // Bus slave state
  reg aw_hold_reg;
  reg w_hold_reg;
  reg [7:0] awaddr_reg;
  reg [31:0] wdata_reg;
  reg [3:0] wstrb_reg;
  reg bvalid_reg;
  reg [1:0] bresp_reg;
  reg rvalid_reg;
  reg [31:0] rdata_reg;
  reg [1:0] rresp_reg;
  reg [31:0] rd_word;
  reg [1:0] rd_resp;
  reg [31:0] wr_merged;
  // Relay state
  reg [5:0] st_reg;
  reg [5:0] latched_reg;
  reg [5:0] relay_reg;
  reg [8:0] hold_reg [0:5];
  reg restore_reg;
  reg [5:0] req_c;
  reg [5:0] ack_c;
  reg [5:0] latched_next;
  reg [5:0] want_c;
  // Panel key synchroniser and edge detect
  reg key_s1_reg;
  reg key_s2_reg;
  reg key_s3_reg;

  wire [7:0] in_state;
  wire [15:0] sig_all;
  wire key_press;
  wire ext_ack;
  wire all_ack;
  integer r;
  integer k;
  integer q;
  genvar gi;

  // Picks one signal of the list by index
  function pick;
    input [15:0] s;
    input [3:0] idx;
    begin
      pick = s[idx];
    end
  endfunction

  // OR of the enabled slots, each with its own polarity
  function relay_req;
    input [27:0] sel;
    input [31:0] ctl;
    input [15:0] s;
    integer j;
    begin
      relay_req = 1'b0;
      for (j = 0; j < `BIO_NUM_SLOT; j = j + 1)
        relay_req = relay_req | (ctl[`BIO_CTL_EN_LSB + j] &
          (pick(s, sel[4 * j +: 4]) ^ ctl[`BIO_CTL_INV_LSB + j]));
    end
  endfunction

  // Byte-lane merge of write data into an old word
  function [31:0] merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0] strb;
    integer b;
    begin
      merge = old;
      for (b = 0; b < 4; b = b + 1)
        if (strb[b])
          merge[8 * b +: 8] = data[8 * b +: 8];
    end
  endfunction

  // True when the word address falls on a relay register pair
  function is_rel;
    input [7:0] a;
    begin
      is_rel = (a >= `BIO_OFF_REL_BASE) &&
        (((a - `BIO_OFF_REL_BASE) >> `BIO_REL_SHIFT) < `BIO_NUM_REL);
    end
  endfunction

  // Relay number of a relay register address
  function [2:0] rel_idx;
    input [7:0] a;
    reg [7:0] d;
    begin
      d = (a - `BIO_OFF_REL_BASE) >> `BIO_REL_SHIFT;
      rel_idx = d[2:0];
    end
  endfunction

  // Hold load; one extra tick, as the first may follow at once
  function [8:0] hold_load;
    input [7:0] h;
    begin
      hold_load = (h == 8'h00) ? 9'h000 : ({1'b0, h} + 9'h001);
    end
  endfunction

  // Eight input channels
  generate
    for (gi = 0; gi < `BIO_NUM_IN; gi = gi + 1)
    begin : g_in
      bio_input_filter u_filter (
        .mclk_i(mclk_i),
        .resetn_i(resetn_i),
        .tick_i(tick_reg),
        .raw_i(sense_input_n_i[gi]),
        .invert_i(incfg_reg[`BIO_INCFG_INV_LSB + gi]),
        .delay_sel_i(incfg_reg[`BIO_INCFG_DEB_LSB + 2 * gi +: 2]),
        .level_o(in_state[gi])
      );
    end
  endgenerate

  assign sig_all = {int_sig_i, in_state};
  assign key_press = key_s2_reg & ~key_s3_reg;
  assign ext_ack = ack_reg[`BIO_ACK_EXT_EN] &
    pick(sig_all, ack_reg[`BIO_ACK_EXT_SEL_LSB +: 4]);
  assign all_ack = key_press | ext_ack | scada_pulse_reg;

  assign relay_o = relay_reg;
  assign nv_latch_o = latched_reg;
  assign input_state_o = in_state;
  assign s_axi_awready = ~aw_hold_reg & ~bvalid_reg;
  assign s_axi_wready = ~w_hold_reg & ~bvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = ~rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  // Millisecond tick; a divider, not a second clock
  always @(posedge mclk_i)
  begin
    if (!resetn_i)
    begin
      tick_cnt_reg <= 16'h0000;
      tick_reg <= 1'b0;
    end
    else if (tick_cnt_reg == TICK_LAST)
    begin
      tick_cnt_reg <= 16'h0000;
      tick_reg <= 1'b1;
    end
    else
    begin
      tick_cnt_reg <= tick_cnt_reg + 16'h0001;
      tick_reg <= 1'b0;
    end
  end

  // Panel key comes from a pin; edge taken after two stages
  always @(posedge mclk_i)
  begin
    if (!resetn_i)
    begin
      key_s1_reg <= 1'b0;
      key_s2_reg <= 1'b0;
      key_s3_reg <= 1'b0;
    end
    else
    begin
      key_s1_reg <= clear_key_i;
      key_s2_reg <= key_s1_reg;
      key_s3_reg <= key_s2_reg;
    end
  end

  // Next latch state and wanted relay state per relay
  always @*
  begin
    req_c = 6'h00;
    ack_c = 6'h00;
    latched_next = latched_reg;
    want_c = 6'h00;
    for (r = 0; r < `BIO_NUM_REL; r = r + 1)
    begin
      req_c[r] = relay_req(sel_reg[r], ctl_reg[r], sig_all);
      ack_c[r] = all_ack | (ctl_reg[r][`BIO_CTL_LATCH] &
        ctl_reg[r][`BIO_CTL_ACKEN] &
        pick(sig_all, ctl_reg[r][`BIO_CTL_ACKSEL_LSB +: 4]));
      // Setting wins over an acknowledge in the same cycle
      if (ctl_reg[r][`BIO_CTL_LATCH] & req_c[r])
        latched_next[r] = 1'b1;
      else if (ack_c[r] & ~req_c[r] & (hold_reg[r] == 9'h000))
        latched_next[r] = 1'b0;
      // A stored latch keeps the relay up even with latching now off
      want_c[r] = latched_next[r] | req_c[r];
    end
  end

  // Relay state, hold timers and restore from nonvolatile store
  always @(posedge mclk_i)
  begin
    if (!resetn_i)
    begin
      st_reg <= 6'h00;
      latched_reg <= 6'h00;
      relay_reg <= 6'h00;
      restore_reg <= 1'b1;
      for (k = 0; k < `BIO_NUM_REL; k = k + 1)
        hold_reg[k] <= 9'h000;
    end
    else if (restore_reg)
    begin
      // Caught one edge after release, never inside the reset branch
      restore_reg <= 1'b0;
      if (nv_valid_i)
      begin
        latched_reg <= nv_latch_i;
        st_reg <= nv_latch_i;
      end
    end
    else
    begin
      latched_reg <= latched_next;
      for (k = 0; k < `BIO_NUM_REL; k = k + 1)
      begin
        // The contact only moves while no hold is pending
        if (hold_reg[k] != 9'h000)
        begin
          if (tick_reg)
            hold_reg[k] <= hold_reg[k] - 9'h001;
        end
        else if (want_c[k] != st_reg[k])
        begin
          st_reg[k] <= want_c[k];
          hold_reg[k] <=
            hold_load(ctl_reg[k][`BIO_CTL_HOLD_LSB +: 8]);
        end
        relay_reg[k] <= st_reg[k] ^ ctl_reg[k][`BIO_CTL_OUTINV];
      end
    end
  end

  // Merged write word for the addressed register
  always @*
  begin
    wr_merged = 32'h0000_0000;
    if (awaddr_reg == `BIO_OFF_INCFG)
      wr_merged = merge(incfg_reg, wdata_reg, wstrb_reg);
    else if (awaddr_reg == `BIO_OFF_ACK)
      wr_merged = merge(ack_reg, wdata_reg, wstrb_reg);
    else if (is_rel(awaddr_reg) && awaddr_reg[2])
      wr_merged = merge(ctl_reg[rel_idx(awaddr_reg)], wdata_reg, wstrb_reg);
    else if (is_rel(awaddr_reg))
      wr_merged = merge({4'h0, sel_reg[rel_idx(awaddr_reg)]},
        wdata_reg, wstrb_reg);
  end

  // Write channels: address and data taken in either order
  always @(posedge mclk_i)
  begin
    if (!resetn_i)
    begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `BIO_RESP_OKAY;
      incfg_reg <= 32'h0000_0000;
      ack_reg <= 32'h0000_0000;
      scada_pulse_reg <= 1'b0;
      for (q = 0; q < `BIO_NUM_REL; q = q + 1)
      begin
        sel_reg[q] <= 28'h000_0000;
        ctl_reg[q] <= 32'h0000_0000;
      end
    end
    else
    begin
      scada_pulse_reg <= 1'b0;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_reg <= 1'b1;
        awaddr_reg <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (bvalid_reg && s_axi_bready)
        bvalid_reg <= 1'b0;
      if (aw_hold_reg && w_hold_reg)
      begin
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= `BIO_RESP_OKAY;
        if (awaddr_reg == `BIO_OFF_INCFG)
          incfg_reg <= wr_merged;
        else if (awaddr_reg == `BIO_OFF_ACK)
        begin
          ack_reg <= wr_merged & `BIO_ACK_MASK;
          scada_pulse_reg <= wr_merged[`BIO_ACK_SCADA];
        end
        else if (awaddr_reg == `BIO_OFF_STAT)
          bresp_reg <= `BIO_RESP_OKAY;
        else if (is_rel(awaddr_reg) && awaddr_reg[2])
          ctl_reg[rel_idx(awaddr_reg)] <= wr_merged & `BIO_CTL_MASK;
        else if (is_rel(awaddr_reg))
          sel_reg[rel_idx(awaddr_reg)] <= wr_merged[27:0];
        else
          bresp_reg <= `BIO_RESP_SLVERR;
      end
    end
  end

  // Read decode; status shows filtered inputs, contacts and latches
  always @*
  begin
    rd_word = 32'h0000_0000;
    rd_resp = `BIO_RESP_OKAY;
    if ({s_axi_araddr[7:2], 2'b00} == `BIO_OFF_INCFG)
      rd_word = incfg_reg;
    else if ({s_axi_araddr[7:2], 2'b00} == `BIO_OFF_ACK)
      rd_word = ack_reg;
    else if ({s_axi_araddr[7:2], 2'b00} == `BIO_OFF_STAT)
      rd_word = {24'h00_0000, in_state} |
        ({26'h000_0000, relay_reg} << `BIO_STAT_REL_LSB) |
        ({26'h000_0000, latched_reg} << `BIO_STAT_LAT_LSB);
    else if (is_rel(s_axi_araddr) && s_axi_araddr[2])
      rd_word = ctl_reg[rel_idx(s_axi_araddr)];
    else if (is_rel(s_axi_araddr))
      rd_word = {4'h0, sel_reg[rel_idx(s_axi_araddr)]};
    else
      rd_resp = `BIO_RESP_SLVERR;
  end

  // Read channel: one read at a time, answer one cycle after address
  always @(posedge mclk_i)
  begin
    if (!resetn_i)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= `BIO_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_word;
      rresp_reg <= rd_resp;
    end
    else if (rvalid_reg && s_axi_rready)
      rvalid_reg <= 1'b0;
  end

endmodule // bio_debounce_latch

`default_nettype wire

// *** verification/bio_field_model.sv ***
// Purpose: Field contacts wired to the binary input pins
// Assumes: The bench sets the wanted contact level of each line
// Notes: A bouncing line toggles every cycle and never settles
`timescale 1ns/1ps
`default_nettype none
module bio_field_model (
  input wire logic mclk_i,
  input wire logic [7:0] contact_i,
  input wire logic [7:0] bounce_i,
  output var logic [7:0] pin_o = 8'h00
);
  // Chatter is the harshest case a debounce counter has to reject
  always @(posedge mclk_i)
  begin
    pin_o <= (contact_i & ~bounce_i) | (~pin_o & bounce_i);
  end
endmodule // bio_field_model
`default_nettype wire

// *** verification/bio_debounce_latch_checker.sv ***
// Purpose: Port-level assertions for the input filter and relay block
// Assumes: Config registers are zero straight after reset
// Notes: Bound to the top module from the bench's top file
`timescale 1ns/1ps
`default_nettype none
module bio_debounce_latch_checker (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic [5:0] nv_latch_i,
  input wire logic nv_valid_i,
  input wire logic [5:0] relay_o,
  input wire logic [5:0] nv_latch_o,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!resetn_i);
  // Address and data taken together, then the response
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_wr_answer;
    !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  chk_write_answer: assert property (s_wr_taken |=> s_wr_answer)
    else $error("write response not two edges after take");
  chk_read_answer: assert property (s_rd_taken |=> s_axi_rvalid)
    else $error("read data not one edge after take");
  chk_read_stands: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before rready");
  chk_resp_stands: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before bready");
  chk_no_reread: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while data pending");
  chk_no_rewrite: assert property (s_axi_bvalid
    |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  chk_err_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'h2
    |-> s_axi_rdata == 32'h0000_0000)
    else $error("error read returned data");
  // Reset must be seen even while it is asserted
  chk_reset_clear: assert property (disable iff (1'b0)
    !resetn_i |=> relay_o == 6'h00 && nv_latch_o == 6'h00)
    else $error("relay state not cleared by reset");
  chk_restore_latch: assert property (
    $rose(resetn_i) && nv_valid_i |=> nv_latch_o == $past(nv_latch_i))
    else $error("latched image not restored");
  chk_restore_relay: assert property (
    $rose(resetn_i) && nv_valid_i |=> ##1 relay_o == $past(nv_latch_i, 2))
    else $error("relay contacts not restored");
endmodule // bio_debounce_latch_checker
`default_nettype wire

// *** verification/test_bio_debounce_latch.sv ***
// Purpose: Self-checking bench for the input filter and relay block
// Assumes: One millisecond is shortened to TK clock cycles
// Notes: Expected results queue up; a monitor compares them in order
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) \
  begin \
    samples_checked++; \
    if ((g) !== (e)) \
    begin \
      err_count++; \
      $display("wrong value t=%0t got %h exp %h", $time, g, e); \
    end \
  end
module test_bio_debounce_latch;
  localparam int TK = 4;
  logic mclk_i, resetn_i = 1'b0, clear_key_i = 1'b0, probe = 1'b0;
  logic nv_valid_i = 1'b0;
  logic [5:0] nv_latch_i = 6'h00, relay_o, nv_latch_o;
  logic [7:0] int_sig_i = 8'h00, contact = 8'h00, bounce = 8'h00;
  logic [7:0] pins, input_state_o, ist;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
  logic [31:0] rs = 32'h0000_8983;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [35:0] exp_q[$];
  logic [35:0] e;
  int dly[4] = '{0, 20, 50, 100};
  int err_count = 0;
  int samples_checked = 0;
  int n;
  bio_field_model field_u (.mclk_i(mclk_i), .contact_i(contact),
    .bounce_i(bounce), .pin_o(pins));
  bio_debounce_latch #(.TICK_CYCLES(TK)) dut_u (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .sense_input_n_i(pins),
    .int_sig_i(int_sig_i), .clear_key_i(clear_key_i),
    .nv_latch_i(nv_latch_i), .nv_valid_i(nv_valid_i),
    .relay_o(relay_o), .nv_latch_o(nv_latch_o),
    .input_state_o(input_state_o), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
  // 40 MHz system clock
  initial
  begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge mclk_i);
  endtask
  // Response ready is raised late so the slave must hold its answer
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] r);
    int k;
    exp_q.push_back({2'h0, r, 32'h0000_0000});
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (k = 0; k < 99; k++)
    begin
      @(posedge mclk_i);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready)
        break;
      if (s_axi_bvalid)
        s_axi_bready <= 1'b1;
    end
    s_axi_bready <= 1'b0;
    if (k == 99)
    begin
      err_count++;
      close_out();
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] r);
    int k;
    exp_q.push_back({2'h1, r, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (k = 0; k < 99; k++)
    begin
      @(posedge mclk_i);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready)
        break;
      if (s_axi_rvalid)
        s_axi_rready <= 1'b1;
    end
    s_axi_rready <= 1'b0;
    if (k == 99)
    begin
      err_count++;
      close_out();
    end
  endtask
  // Expected {input_state_o, relay_o} at the next edge
  task automatic pchk(input logic [13:0] x);
    exp_q.push_back({2'h2, 20'h0_0000, x});
    probe <= 1'b1;
    @(posedge mclk_i);
    probe <= 1'b0;
    @(posedge mclk_i);
  endtask
  task automatic do_reset();
    resetn_i <= 1'b0;
    repeat (6) @(posedge mclk_i);
    resetn_i <= 1'b1;
  endtask
  // Oldest note is matched against each answer as it appears
  always @(posedge mclk_i)
  begin
    if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready)
      || probe)
    begin
      e = exp_q.pop_front();
      case (e[35:34])
        2'h0: `CHK(s_axi_bresp, e[33:32])
        2'h1: `CHK({s_axi_rresp, s_axi_rdata}, e[33:0])
        default: `CHK({input_state_o, relay_o}, e[13:0])
      endcase
    end
  end
  initial
  begin
    @(posedge mclk_i);
    do_reset();
    cyc(3);
    pchk({8'h00, 6'h00});
    rd(8'h00, 32'h0000_0000, 2'h0);
    rd(8'hFC, 32'h0000_0000, 2'h2);
    wr(8'hFC, 32'h1234_5678, 2'h2);
    // Only byte lane 0 may change the input word
    s_axi_wstrb <= 4'h1;
    wr(8'h00, 32'hFFFF_FFFF, 2'h0);
    s_axi_wstrb <= 4'hF;
    rd(8'h00, 32'h0000_00FF, 2'h0);
    $display("test reset done");
    wr(8'h00, 32'h0000_0081, 2'h0);
    cyc(4);
    pchk({8'h81, 6'h00});
    contact <= 8'h01;
    cyc(6);
    pchk({8'h80, 6'h00});
    $display("test polarity done");
    contact <= 8'h00;
    wr(8'h00, 32'h00E4_0000, 2'h0);
    cyc(6);
    ist = 8'h00;
    for (n = 1; n < 4; n++)
    begin
      contact[n] <= 1'b1;
      cyc((dly[n] - 1) * TK);
      pchk({ist, 6'h00});
      ist[n] = 1'b1;
      cyc(3 * TK + 2);
      pchk({ist, 6'h00});
    end
    // A chattering contact keeps restarting the count
    bounce <= 8'h02;
    contact <= 8'h0C;
    cyc(30 * TK);
    pchk({ist, 6'h00});
    bounce <= 8'h00;
    cyc(23 * TK);
    ist = 8'h0C;
    pchk({ist, 6'h00});
    $display("test debounce done");
    wr(8'h10, 32'h0EDC_BA98, 2'h0);
    for (n = 0; n < 8; n++)
    begin
      rs = xs(rs);
      int_sig_i <= rs[15:8];
      wr(8'h14, {17'h0, rs[7], rs[6:0], rs[22:16]}, 2'h0);
      cyc(4);
      pchk({ist, 5'h00,
        |((rs[14:8] ^ rs[6:0]) & rs[22:16]) ^ rs[7]});
    end
    $display("test combine done");
    int_sig_i <= 8'h01;
    wr(8'h14, 32'h0013_8001, 2'h0);
    wr(8'h04, 32'h0000_01A1, 2'h0);
    int_sig_i <= 8'h00;
    cyc(4);
    pchk({ist, 6'h01});
    // Network, key, global signal and per-relay signal in turn
    for (n = 0; n < 4; n++)
    begin
      int_sig_i <= 8'h01;
      cyc(3);
      int_sig_i <= 8'h00;
      cyc(4);
      pchk({ist, 6'h01});
      clear_key_i <= (n == 1);
      int_sig_i <= (n == 2) ? 8'h04 : (n == 3) ? 8'h02 : 8'h00;
      if (n == 0)
        wr(8'h04, 32'h0000_01A1, 2'h0);
      cyc(4);
      clear_key_i <= 1'b0;
      int_sig_i <= 8'h00;
      cyc(6);
      pchk({ist, 6'h00});
    end
    int_sig_i <= 8'h01;
    cyc(3);
    int_sig_i <= 8'h00;
    wr(8'h14, 32'h0000_0001, 2'h0);
    cyc(4);
    pchk({ist, 6'h01});
    rd(8'h08, {16'h0001, 8'h01, ist}, 2'h0);
    wr(8'h04, 32'h0000_01A1, 2'h0);
    cyc(4);
    pchk({ist, 6'h00});
    $display("test latch done");
    wr(8'h14, 32'h0500_0001, 2'h0);
    int_sig_i <= 8'h01;
    cyc(2);
    int_sig_i <= 8'h00;
    cyc(2 * TK);
    pchk({ist, 6'h01});
    cyc(6 * TK);
    pchk({ist, 6'h00});
    $display("test hold done");
    nv_latch_i <= 6'h2A;
    nv_valid_i <= 1'b1;
    do_reset();
    cyc(4);
    pchk({ist, 6'h2A});
    nv_valid_i <= 1'b0;
    do_reset();
    cyc(4);
    pchk({ist, 6'h00});
    $display("test restore done");
    close_out();
  end
endmodule // test_bio_debounce_latch
bind bio_debounce_latch bio_debounce_latch_checker chk_u (
  .mclk_i(mclk_i), .resetn_i(resetn_i), .nv_latch_i(nv_latch_i),
  .nv_valid_i(nv_valid_i), .relay_o(relay_o), .nv_latch_o(nv_latch_o),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready));
`default_nettype wire
